//--- hdl/mbsrh_consts.svh
/*
  Constants for the slave request handler: timing, register
  offsets, limits and codes. Assumes the includer sets the nettype.
*/
// What this block does
// - Answer local 500 ms, fan 1 s.
// - Accept only codes 03, 04, 06, 16.
// - Limit 14 local, 9 fan registers.
// - Fan registers served in every mode.
// - Passthrough mode freezes per-fan local registers.
// - Otherwise per-fan registers track display values.
// - Fan reads proceed without stopping control.
// - Summary values at input registers 1 to 6.
// - Speed writes act only in three modes.
// - Speed follows array register or setpoint low word.
// - 32-bit values split high-word-first across registers.
`ifndef MBSRH_CONSTS_SVH
`define MBSRH_CONSTS_SVH
// ==========================================================
// Timing
`define MBSRH_CLK_MHZ          250
`define MBSRH_LOCAL_MS         500
`define MBSRH_FAN_MS           1000
`define MBSRH_LOCAL_CYC        (`MBSRH_LOCAL_MS * 250000)
`define MBSRH_FAN_CYC          (`MBSRH_FAN_MS * 250000)
// ==========================================================
// Function codes and exceptions
`define MBSRH_FC_RD_HOLD       8'h03
`define MBSRH_FC_RD_INPUT      8'h04
`define MBSRH_FC_WR_SINGLE     8'h06
`define MBSRH_FC_WR_MULTI      8'h10
`define MBSRH_EX_ILL_FUNC      8'h01
`define MBSRH_EX_ILL_VALUE     8'h03
`define MBSRH_MAX_LOCAL        16'h000e
`define MBSRH_MAX_FAN          16'h0009
// ==========================================================
// Register map
`define MBSRH_HR_MODE          16'h0000
`define MBSRH_HR_ARRAY_SPEED   16'h0004
`define MBSRH_HR_SETP_HI       16'h0010
`define MBSRH_HR_SETP_LO       16'h0011
`define MBSRH_HR_LOCAL_TOP     16'h0017
`define MBSRH_IR_TOP           16'h000d
`define MBSRH_FAN_BASE         16'h1000
`define MBSRH_FAN_REGS         4
`endif

//--- hdl/mbsrh_handler.sv
/*
  Slave request handler: validates decoded requests, serves local
  registers, relays fan registers, gates speed control by mode.
  Assumes framing and CRC are done outside; one request at a time.
*/
`include "mbsrh_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module mbsrh_handler #(
  parameter int NFAN      = 4,
  parameter int LOCAL_CYC = `MBSRH_LOCAL_CYC,
  parameter int FAN_CYC   = `MBSRH_FAN_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire logic                       req_valid,
  input  wire mbsrh_pkg::mbsrh_req_t      req,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output mbsrh_pkg::mbsrh_rsp_t           rsp,
  output logic                            rsp_last,
  input  wire mbsrh_pkg::mbsrh_fan_t [NFAN-1:0] fan_live,
  input  wire logic [15:0]                sum_vals [0:5],
  input  wire logic [31:0]                total_power,
  output logic                            fan_req,
  output logic [15:0]                     fan_addr,
  input  wire logic                       fan_ack,
  input  wire logic [15:0]                fan_rdata,
  output logic [15:0]                     speed_cmd,
  output logic                            timeout_err
);
  import mbsrh_pkg::*;
  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_LOCAL, S_FAN_REQ, S_FAN_WAIT, S_DONE} mbsrh_st_t;
  mbsrh_st_t   st_q, st_d;
  mbsrh_req_t  cur_q;
  logic [15:0] idx_q;
  logic [15:0] hold_q [0:23];
  mbsrh_fan_t [NFAN-1:0] fan_store_q;
  logic [15:0] speed_q;
  logic        rsp_valid_q, rsp_last_q, fan_req_q, tout_q;
  mbsrh_rsp_t  rsp_q;
  mbsrh_mode_t mode;
  // ==========================================================
  // Request classification
  wire is_read   = cur_q.func == `MBSRH_FC_RD_HOLD || cur_q.func == `MBSRH_FC_RD_INPUT;
  wire is_write  = cur_q.func == `MBSRH_FC_WR_SINGLE || cur_q.func == `MBSRH_FC_WR_MULTI;
  wire func_ok   = is_read || is_write;
  wire is_fan    = cur_q.func != `MBSRH_FC_RD_INPUT && cur_q.addr >= `MBSRH_FAN_BASE;
  wire [15:0] nreg = (cur_q.func == `MBSRH_FC_WR_SINGLE) ? 16'h0001 : cur_q.count;
  wire len_ok    = nreg != 16'h0000 &&
                   nreg <= (is_fan ? `MBSRH_MAX_FAN : `MBSRH_MAX_LOCAL);
  wire [15:0] ra = cur_q.addr + idx_q;
  wire last_word = (idx_q + 16'h0001) >= nreg;
  wire timed_out;
  assign mode = (hold_q[0][2:0] <= 3'h3) ? mbsrh_mode_t'(hold_q[0][2:0]) : MBSRH_MODE_OTHER;
  wire ctl_ok = mode == MBSRH_MODE_DRIVE || mode == MBSRH_MODE_CONST ||
                mode == MBSRH_MODE_PASS;
  wire [31:0] setp = {hold_q[16], hold_q[17]};
  // ==========================================================
  // Local read mux, split 32-bit values high word first
  logic [15:0] local_rd;
  always_comb begin
    local_rd = 16'h0000;
    if (cur_q.func == `MBSRH_FC_RD_INPUT) begin
      if (ra >= 16'h0001 && ra <= 16'h0006) begin
        local_rd = sum_vals[ra[2:0] - 3'h1];
      end else if (ra == 16'h0007) begin
        local_rd = total_power[31:16];
      end else if (ra == 16'h0008) begin
        local_rd = total_power[15:0];
      end
    end else if (ra < 16'h0018) begin
      local_rd = hold_q[ra[4:0]];
    end else if (ra < 16'h0018 + NFAN * 3) begin
      local_rd = 16'(fan_store_q[(ra - 16'h0018) / 3] >> (16 * (2 - (ra - 16'h0018) % 3)));
    end
  end
  // ==========================================================
  // Deadline watch: local 500 ms, fan 1 s
  mbsrh_timer #(.W(30)) u_timer (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .start   (st_q == S_IDLE && req_valid),
    .limit   (is_fan ? 30'(FAN_CYC) : 30'(LOCAL_CYC)),
    .stop    (st_q == S_DONE),
    .expired (timed_out)
  );
  // ==========================================================
  // Sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE:     if (req_valid) st_d = S_CHECK;
      S_CHECK:    st_d = (!func_ok || !len_ok) ? S_DONE : (is_fan ? S_FAN_REQ : S_LOCAL);
      S_LOCAL:    if (last_word) st_d = S_DONE;
      S_FAN_REQ:  st_d = S_FAN_WAIT;
      S_FAN_WAIT: if (fan_ack) st_d = last_word ? S_DONE : S_FAN_REQ;
                  else if (timed_out) st_d = S_DONE;
      S_DONE:     st_d = S_IDLE;
      default:    st_d = S_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) st_q <= S_IDLE;
    else st_q <= st_d;
  end
  // Request capture and word index
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cur_q <= '0;
      idx_q <= 16'h0000;
    end else if (st_q == S_IDLE && req_valid) begin
      cur_q <= req;
      idx_q <= 16'h0000;
    end else if ((st_q == S_LOCAL) || (st_q == S_FAN_WAIT && fan_ack)) begin
      idx_q <= idx_q + 16'h0001;
    end
  end
  // ==========================================================
  // Holding registers; untouched on any refused request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 24; i++) hold_q[i] <= 16'h0000;
    end else if (st_q == S_LOCAL && is_write && ra < 16'h0018) begin
      hold_q[ra[4:0]] <= cur_q.wdata;
    end
  end
  // Per-fan mirror tracks live values except in passthrough
  generate
    for (genvar f = 0; f < NFAN; f++) begin : g_fan
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) fan_store_q[f] <= '0;
        else if (mode != MBSRH_MODE_PASS) fan_store_q[f] <= fan_live[f];
      end
    end
  endgenerate
  // Speed follows array register or setpoint by mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) speed_q <= 16'h0000;
    else if (ctl_ok && mode == MBSRH_MODE_CONST) speed_q <= setp[15:0];
    else if (ctl_ok) speed_q <= hold_q[4];
  end
  // ==========================================================
  // Response, fan request and timeout outputs, all registered; fan_addr is combinational
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_last_q  <= 1'b0;
      rsp_q       <= '0;
      fan_req_q   <= 1'b0;
      tout_q      <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      rsp_last_q  <= 1'b0;
      fan_req_q   <= st_d == S_FAN_REQ;
      if (st_q == S_CHECK && !func_ok) begin
        rsp_valid_q <= 1'b1;
        rsp_last_q  <= 1'b1;
        rsp_q       <= '{exc: 1'b1, code: `MBSRH_EX_ILL_FUNC, rdata: 16'h0000};
      end else if (st_q == S_CHECK && !len_ok) begin
        rsp_valid_q <= 1'b1;
        rsp_last_q  <= 1'b1;
        rsp_q       <= '{exc: 1'b1, code: `MBSRH_EX_ILL_VALUE, rdata: 16'h0000};
      end else if (st_q == S_LOCAL) begin
        rsp_valid_q <= 1'b1;
        rsp_last_q  <= last_word;
        rsp_q       <= '{exc: 1'b0, code: cur_q.func, rdata: local_rd};
      end else if (st_q == S_FAN_WAIT && fan_ack) begin
        rsp_valid_q <= 1'b1;
        rsp_last_q  <= last_word;
        rsp_q       <= '{exc: 1'b0, code: cur_q.func, rdata: fan_rdata};
      end
      if (st_q == S_FAN_WAIT && !fan_ack && timed_out) tout_q <= 1'b1;
      else if (st_q == S_IDLE && req_valid) tout_q <= 1'b0;
    end
  end
  assign req_ready   = st_q == S_IDLE;
  assign rsp_valid   = rsp_valid_q;
  assign rsp_last    = rsp_last_q;
  assign rsp         = rsp_q;
  assign fan_req     = fan_req_q;
  assign fan_addr    = ra - `MBSRH_FAN_BASE;
  assign speed_cmd   = speed_q;
  assign timeout_err = tout_q;
endmodule // mbsrh_handler
`default_nettype wire

//--- hdl/mbsrh_pkg.sv
/*
  Types for the request handler. Assumes consts header beside it.
*/
package mbsrh_pkg;
  typedef enum logic [2:0] {
    MBSRH_MODE_MONITOR,
    MBSRH_MODE_DRIVE,
    MBSRH_MODE_CONST,
    MBSRH_MODE_PASS,
    MBSRH_MODE_OTHER
  } mbsrh_mode_t;
  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] count;
    logic [15:0] wdata;
  } mbsrh_req_t;
  typedef struct packed {
    logic        exc;
    logic [7:0]  code;
    logic [15:0] rdata;
  } mbsrh_rsp_t;
  typedef struct packed {
    logic [15:0] power;
    logic [15:0] speed;
    logic [15:0] temp;
  } mbsrh_fan_t;
endpackage

//--- hdl/mbsrh_timer.sv
/*
  Deadline counter: starts on a pulse, flags expiry. Single clock.
*/
`timescale 1ns/100ps
`default_nettype none
module mbsrh_timer #(
  parameter int W = 30
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] limit,
  input  wire logic         stop,
  output logic              expired
);
  logic [W-1:0] cnt_q;
  logic         run_q;
  // ==========================================================
  // Counter runs until stop or limit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= '0;
      run_q <= 1'b1;
    end else if (stop || expired) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign expired = run_q && (cnt_q >= limit);
endmodule // mbsrh_timer
`default_nettype wire

//--- sim/mbsrh_fan_model.sv
/*
  Fan network model: answers each fan request quickly or slowly.
  Assumes one outstanding request, single clock.
*/
`timescale 1ns/100ps
`default_nettype none
module mbsrh_fan_model (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        fan_req,
  input  wire logic [15:0] fan_addr,
  input  wire logic        slow,
  output logic             fan_ack,
  output logic [15:0]      fan_rdata
);
  logic [15:0] addr_q;
  logic [3:0]  wait_q;
  logic        busy_q;
  // Data toggles between answers so a stale word never matches
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {fan_ack, fan_rdata, addr_q, wait_q, busy_q} <= '0;
    end else begin
      fan_ack   <= 1'b0;
      fan_rdata <= ~fan_rdata;
      if (fan_req) begin
        busy_q <= 1'b1;
        addr_q <= fan_addr;
        wait_q <= slow ? 4'h6 : 4'h0;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q    <= 1'b0;
        fan_ack   <= 1'b1;
        fan_rdata <= addr_q ^ 16'hc3c3; // Word tied to the fan address asked
      end
    end
  end
endmodule // mbsrh_fan_model
`default_nettype wire

//--- sim/mbsrh_handler_tb.sv
/*
  Testbench: master-side request tasks and checked sequences.
  Assumes handler, fan model and monitor compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module mbsrh_handler_tb;
  import mbsrh_pkg::*;
  logic clk_sys, arst_n, req_valid, req_ready, rsp_valid, rsp_last, fan_req, fan_ack, slow, timeout_err;
  mbsrh_req_t      req;
  mbsrh_rsp_t      rsp;
  mbsrh_fan_t [3:0] fan_live;
  logic [15:0] sum_vals [0:5];
  logic [15:0] fan_addr, fan_rdata, speed_cmd, prev, words[$];
  logic [31:0] total_power;
  logic [7:0]  code_seen;
  int mismatches, cmp_count;
  mbsrh_handler #(.LOCAL_CYC(50), .FAN_CYC(100)) DUT (.*);
  mbsrh_fan_model u_fan (.*);
  // ==========================================
  // Clock, verdict, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end
  // ==========================================
  // Compare and request tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  // Offered at a falling edge, held until taken, words gathered
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c, input logic [15:0] w);
    int n;
    words.delete();
    code_seen = 8'h00;
    req_valid = 1'b1;
    req = '{f, a, c, w};
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin @(negedge clk_sys); n++; end
    @(negedge clk_sys);
    req_valid = 1'b0;
    // Waits far past both reply deadlines
    for (n = 0; n < 300; n++) begin
      if (rsp_valid === 1'b1) begin
        words.push_back(rsp.rdata);
        if (rsp.exc === 1'b1) code_seen = rsp.code;
        if (rsp_last === 1'b1) break;
      end
      if (timeout_err === 1'b1) break;
      @(negedge clk_sys);
    end
    chk("reply_done", 16'h0001, 16'(n < 300));
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic fan_rd(input logic [15:0] a, input logic [15:0] c);
    xfer(8'h03, 16'h1000 + a, c, 16'h0000);
    chk("fan_words", c, 16'(words.size()));
    foreach (words[k]) chk("fan_word", (a + 16'(k)) ^ 16'hc3c3, words[k]);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {arst_n, req_valid, slow} = 3'b000;
    req = '0;
    total_power = 32'h1234abcd;
    for (int i = 0; i < 6; i++) sum_vals[i] = 16'h0100 + 16'(i);
    for (int i = 0; i < 4; i++) fan_live[i] = '{16'h0200 + 16'(i), 16'h0300 + 16'(i), 16'h0400 + 16'(i)};
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    xfer(8'h04, 16'h0001, 16'h0008, 16'h0000);
    for (int k = 0; k < 6; k++) chk("summary", sum_vals[k], words[k]);
    chk("power_hi", total_power[31:16], words[6]);
    chk("power_lo", total_power[15:0], words[7]);
    xfer(8'h04, 16'h0000, 16'h000e, 16'h0000);
    chk("local_14", 16'h000e, 16'(words.size()));
    for (int i = 0; i < 2; i++) begin
      xfer(8'h03, 16'h0000, i ? 16'h0000 : 16'h000f, 16'h0000);
      chk("len_code", 16'h0003, {8'h00, code_seen});
    end
    for (int i = 0; i < 5; i++) begin
      xfer(i == 0 ? 8'h01 : i == 1 ? 8'h02 : i == 2 ? 8'h05 : i == 3 ? 8'h0f : 8'h11, 16'h0000, 16'h0001, 16'h0000);
      chk("func_code", 16'h0001, {8'h00, code_seen});
    end
    xfer(8'h03, 16'h001b, 16'h0003, 16'h0000);
    chk("mirror_pwr", fan_live[1].power, words[0]);
    chk("mirror_spd", fan_live[1].speed, words[1]);
    chk("mirror_tmp", fan_live[1].temp, words[2]);
    fan_rd(16'h0005, 16'h0002);
    prev = speed_cmd;
    // Drive comes before passthrough
    for (int i = 0; i < 4; i++) begin
      xfer(8'h06, 16'h0000, 16'h0001, i == 0 ? 16'h0 : i == 1 ? 16'h4 : i == 2 ? 16'h1 : 16'h3);
      xfer(8'h10, 16'h0004, 16'h0001, 16'h0040 + 16'(i));
      if (i >= 2) prev = 16'h0040 + 16'(i);
      chk("speed_cmd", prev, speed_cmd);
    end
    xfer(8'h10, 16'h0004, 16'h000f, 16'h0077);
    chk("speed_kept", prev, speed_cmd);
    fan_live[1] = '{16'h0aaa, 16'h0bbb, 16'h0ccc};
    repeat (10) @(negedge clk_sys);
    xfer(8'h03, 16'h001b, 16'h0003, 16'h0000);
    chk("frozen_pwr", 16'h0201, words[0]);
    slow = 1'b1;
    fan_rd(16'h0010, 16'h0009);
    xfer(8'h03, 16'h1000, 16'h000a, 16'h0000);
    chk("fan_len", 16'h0003, {8'h00, code_seen});
    give_verdict();
  end
endmodule // mbsrh_handler_tb
`default_nettype wire

//--- sim/mbsrh_monitor.sv
/*
  Port checker for the request handler.
  Assumes mbsrh_pkg compiled first and sim-sized deadlines.
*/
`timescale 1ns/100ps
`default_nettype none
module mbsrh_monitor #(
  parameter int LOCAL_CYC = 50,
  parameter int FAN_CYC   = 100
) (
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  input wire logic                  req_valid,
  input wire mbsrh_pkg::mbsrh_req_t req,
  input wire logic                  req_ready,
  input wire logic                  rsp_valid,
  input wire mbsrh_pkg::mbsrh_rsp_t rsp,
  input wire logic                  rsp_last,
  input wire logic                  fan_req,
  input wire logic                  fan_ack,
  input wire logic                  timeout_err
);
  import mbsrh_pkg::*;
  // ==========================================
  // Request decode, count ignored on single writes
  wire take    = req_valid && req_ready;
  wire fan_a   = (req.func != 8'h04) && (req.addr >= 16'h1000);
  wire bad_fc  = !(req.func inside {8'h03, 8'h04, 8'h06, 8'h10});
  wire bad_len = (req.func != 8'h06) && (req.count == 16'h0000 || req.count > (fan_a ? 16'h0009 : 16'h000e));
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_good; take && !bad_fc && !bad_len; endsequence
  sequence s_exc(logic [7:0] c); rsp_valid && rsp.exc && rsp.code == c && rsp_last; endsequence
  // ==========================================
  // Checks
  a_bad_func: assert property (take && bad_fc |-> ##2 s_exc(8'h01))
    else $error("bad code not refused");
  a_bad_length: assert property (take && !bad_fc && bad_len |-> ##2 s_exc(8'h03))
    else $error("long request not refused");
  a_exc_no_relay: assert property (take && (bad_fc || bad_len) |=> !fan_req [*3])
    else $error("refused request reached fans");
  a_busy_refuse: assert property (take |=> !req_ready)
    else $error("ready while busy");
  a_local_deadline: assert property (s_good and !fan_a |-> ##[2:LOCAL_CYC] rsp_last)
    else $error("local reply late");
  a_fan_deadline: assert property (s_good and fan_a |-> ##[2:FAN_CYC] (rsp_last || timeout_err))
    else $error("fan reply late");
  a_fan_relay: assert property (s_good and fan_a |-> ##2 fan_req)
    else $error("fan not asked");
  a_ack_word: assert property (fan_ack && !req_ready |=> rsp_valid)
    else $error("fan word not passed on");
  a_last_word: assert property (rsp_last |-> rsp_valid)
    else $error("last flag without word");
endmodule // mbsrh_monitor
bind mbsrh_handler mbsrh_monitor #(.LOCAL_CYC(LOCAL_CYC), .FAN_CYC(FAN_CYC)) u_mon (
  .clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .rsp_last(rsp_last), .fan_req(fan_req), .fan_ack(fan_ack),
  .timeout_err(timeout_err));
`default_nettype wire
